//--- verilog/rdm_regbank.sv
// discharge control and mode setting 0 configuration register bank
`timescale 1ns/100ps
// Contract
// - bit 3 low: bleed core buck output while it is disabled
// - bit 2 low: bleed system buck output while it is disabled
// - bit 1 low: bleed always-on regulator output while disabled
// - bit 0 low: bleed system linear regulator output while disabled
// - setup bit 7 high requests ship mode for mode setting 0
// - pin-select low: mode comes only from internal request bits
// - pin-select high: mode comes only from external mode pins
// - pin-select reset value loads from a one-bit nonvolatile cell
// - voltage code: 0.5V plus 25mV steps, saturate 1.5V, all ones 1.8V
// - voltage code resets to the 1.00V code from nonvolatile storage
// - setup register is read and written; reads return last write
module rdm_regbank
    import rdm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        nv_pin_select,
    input  wire logic [5:0]  nv_voltage_code,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr_en,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd_en,
    output logic      [7:0]  reg_rdata,
    input  wire logic        core_buck_enabled,
    input  wire logic        system_buck_enabled,
    input  wire logic        always_on_regulator_enabled,
    input  wire logic        system_linear_regulator_enabled,
    output logic             core_buck_bleed_on,
    output logic             system_buck_bleed_on,
    output logic             always_on_reg_bleed_on,
    output logic             system_linreg_bleed_on,
    input  wire logic        mode_pin_low,
    input  wire logic        mode_pin_high,
    input  wire logic        mode_request_bit_low,
    input  wire logic        mode_request_bit_high,
    output logic      [1:0]  mode_select,
    output logic             ship_mode_request,
    output logic             pin_driven_mode_select,
    output logic      [5:0]  core_buck_voltage_code,
    output logic      [10:0] core_buck_millivolts
);
    typedef struct packed
    {
        logic [7:0] discharge;
        logic [7:0] setup_a;
        logic [7:0] rdata;
        logic [3:0] bleed;
        logic [1:0] mode_sel;
        logic       ship;
    } rdm_regs_s;

    rdm_regs_s state;
    rdm_regs_s next_state;

    logic wr_dis;
    logic wr_setup;

    assign wr_dis   = reg_wr_en && (reg_addr == RDM_OFS_DISCHARGE);
    assign wr_setup = reg_wr_en && (reg_addr == RDM_OFS_MODE0_A);

    // register writes, read mux and the derived controls
    // outputs except reg_rdata and core_buck_millivolts follow the new register value at the same edge as the write
    always_comb
    begin
        next_state = state;
        if (wr_dis)
        begin
            next_state.discharge = reg_wdata; // reserved bits stored only
        end
        if (wr_setup)
        begin
            next_state.setup_a = reg_wdata;
        end
        if (reg_rd_en)
        begin
            unique case (reg_addr)
                RDM_OFS_DISCHARGE: next_state.rdata = state.discharge;
                RDM_OFS_MODE0_A:   next_state.rdata = state.setup_a;
                default:           next_state.rdata = RDM_RST_RDATA; // unmapped reads zero
            endcase
        end
        // bleed only when disabled and the off bit is clear
        next_state.bleed[RDM_BIT_CORE_BUCK_OFF] =
            !core_buck_enabled && !next_state.discharge[RDM_BIT_CORE_BUCK_OFF];
        next_state.bleed[RDM_BIT_SYS_BUCK_OFF] =
            !system_buck_enabled && !next_state.discharge[RDM_BIT_SYS_BUCK_OFF];
        next_state.bleed[RDM_BIT_ALWAYS_ON_OFF] =
            !always_on_regulator_enabled
            && !next_state.discharge[RDM_BIT_ALWAYS_ON_OFF];
        next_state.bleed[RDM_BIT_SYS_LINREG_OFF] =
            !system_linear_regulator_enabled
            && !next_state.discharge[RDM_BIT_SYS_LINREG_OFF];
        // exactly one source steers the mode, never a mix
        if (next_state.setup_a[RDM_BIT_PIN_SELECT])
        begin
            next_state.mode_sel = {mode_pin_high, mode_pin_low};
        end
        else
        begin
            next_state.mode_sel = {mode_request_bit_high, mode_request_bit_low};
        end
        next_state.ship = next_state.setup_a[RDM_BIT_SHIP];
    end

    // synchronous reset samples the nonvolatile defaults while held
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state.discharge <= RDM_RST_DISCHARGE;
            state.setup_a   <= {1'b0, nv_pin_select, nv_voltage_code};
            state.rdata     <= RDM_RST_RDATA;
            state.bleed     <= 4'h0;
            state.mode_sel  <= 2'h0;
            state.ship      <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // millivolt decode lags the code by one edge
    rdm_volt_decode u_decode
    (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .code       (state.setup_a[RDM_CODE_MSB:RDM_CODE_LSB]),
        .millivolts (core_buck_millivolts)
    );

    assign reg_rdata              = state.rdata;
    assign core_buck_bleed_on     = state.bleed[RDM_BIT_CORE_BUCK_OFF];
    assign system_buck_bleed_on   = state.bleed[RDM_BIT_SYS_BUCK_OFF];
    assign always_on_reg_bleed_on = state.bleed[RDM_BIT_ALWAYS_ON_OFF];
    assign system_linreg_bleed_on = state.bleed[RDM_BIT_SYS_LINREG_OFF];
    assign mode_select            = state.mode_sel;
    assign ship_mode_request      = state.ship;
    assign pin_driven_mode_select = state.setup_a[RDM_BIT_PIN_SELECT];
    assign core_buck_voltage_code = state.setup_a[RDM_CODE_MSB:RDM_CODE_LSB];

    // checks on the bank's own outputs
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_write_setup;
        wr_setup;
    endsequence

    sequence s_read_setup;
        reg_rd_en && (reg_addr == RDM_OFS_MODE0_A) && !wr_setup;
    endsequence

    // the edge right after reset still shows the cleared bleed, so skip it
    a_core_bleed_gate: assert property (
        !$past(rst) |->
            core_buck_bleed_on == (!$past(core_buck_enabled)
            && !state.discharge[RDM_BIT_CORE_BUCK_OFF]))
        else $error("core buck bleed does not follow enable and off bit");

    a_sys_buck_bleed: assert property (
        wr_dis && reg_wdata[RDM_BIT_SYS_BUCK_OFF] |=> !system_buck_bleed_on)
        else $error("system buck bleed on while its off bit is set");

    a_aon_bleed_gate: assert property (
        !always_on_regulator_enabled && !wr_dis
            && !state.discharge[RDM_BIT_ALWAYS_ON_OFF] |=> always_on_reg_bleed_on)
        else $error("always-on regulator bleed missing while disabled");

    a_linreg_bleed_off: assert property (
        system_linear_regulator_enabled |=> !system_linreg_bleed_on)
        else $error("linear regulator bleed on while enabled");

    a_ship_follows_write: assert property (
        s_write_setup |=> ship_mode_request == $past(reg_wdata[RDM_BIT_SHIP]))
        else $error("ship request does not follow written bit");

    a_mode_from_bits: assert property (
        !$past(rst) && !pin_driven_mode_select |->
            mode_select == $past({mode_request_bit_high, mode_request_bit_low}))
        else $error("mode not taken from request bits");

    a_mode_from_pins: assert property (
        !$past(rst) && pin_driven_mode_select |->
            mode_select == $past({mode_pin_high, mode_pin_low}))
        else $error("mode not taken from pins");

    a_setup_readback: assert property (
        s_read_setup ##1 1'b1 |-> reg_rdata == $past(state.setup_a))
        else $error("setup register readback differs from stored value");

    a_pin_sel_write: assert property (
        s_write_setup |=> pin_driven_mode_select == $past(reg_wdata[RDM_BIT_PIN_SELECT]))
        else $error("pin select does not follow written bit");

    a_discharge_readback: assert property (
        reg_rd_en && (reg_addr == RDM_OFS_DISCHARGE) |=> reg_rdata == $past(state.discharge))
        else $error("discharge register readback differs from stored value");

    // read data must not drift between reads
    a_rdata_holds: assert property (
        !reg_rd_en |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    a_reset_defaults: assert property (
        $past(rst) |-> state.discharge == RDM_RST_DISCHARGE
            && pin_driven_mode_select == $past(nv_pin_select)
            && core_buck_voltage_code == $past(nv_voltage_code))
        else $error("reset defaults not loaded");

    a_decode_top_code: assert property (
        core_buck_voltage_code == RDM_CODE_FIXED && $stable(core_buck_voltage_code)
            |=> core_buck_millivolts == RDM_MV_FIXED)
        else $error("all-ones code does not give the fixed voltage");

    a_decode_saturate: assert property (
        core_buck_voltage_code > RDM_CODE_SAT && core_buck_voltage_code != RDM_CODE_FIXED
            ##1 $stable(core_buck_voltage_code) |-> core_buck_millivolts == RDM_MV_SAT)
        else $error("high codes do not saturate");
endmodule

//--- common/rdm_pkg.sv
// constants for the regulator discharge and mode setting 0 register bank
package rdm_pkg;
    // register offsets on the internal register port
    localparam logic [7:0] RDM_OFS_DISCHARGE = 8'h21;
    localparam logic [7:0] RDM_OFS_MODE0_A   = 8'h22;

    // output_discharge_control field positions
    localparam int RDM_BIT_CORE_BUCK_OFF   = 3;
    localparam int RDM_BIT_SYS_BUCK_OFF    = 2;
    localparam int RDM_BIT_ALWAYS_ON_OFF   = 1;
    localparam int RDM_BIT_SYS_LINREG_OFF  = 0;

    // mode_zero_setup_a field positions
    localparam int RDM_BIT_SHIP            = 7;
    localparam int RDM_BIT_PIN_SELECT      = 6;
    localparam int RDM_CODE_MSB            = 5;
    localparam int RDM_CODE_LSB            = 0;

    // reset values
    localparam logic [7:0] RDM_RST_DISCHARGE = 8'h00;
    localparam logic [5:0] RDM_RST_CODE      = 6'h14;
    localparam logic       RDM_RST_PIN_SEL   = 1'b0;
    localparam logic [7:0] RDM_RST_RDATA     = 8'h00;

    // core buck voltage decode, millivolts
    localparam logic [5:0]  RDM_CODE_SAT      = 6'h28;
    localparam logic [5:0]  RDM_CODE_FIXED    = 6'h3f;
    localparam logic [10:0] RDM_MV_BASE       = 11'h1f4;
    localparam logic [10:0] RDM_MV_STEP       = 11'h019;
    localparam logic [10:0] RDM_MV_SAT        = 11'h5dc;
    localparam logic [10:0] RDM_MV_FIXED      = 11'h708;
    localparam logic [10:0] RDM_MV_RST        = 11'h3e8;
endpackage

//--- verilog/rdm_volt_decode.sv
// core buck voltage code to millivolt decoder with registered output
`timescale 1ns/100ps
module rdm_volt_decode
    import rdm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [5:0]  code,
    output logic      [10:0] millivolts
);
    typedef struct packed
    {
        logic [10:0] mv;
    } rdm_dec_s;

    rdm_dec_s state;
    rdm_dec_s next_state;

    // linear range, then saturation, then the fixed top code
    always_comb
    begin
        next_state = state;
        if (code == RDM_CODE_FIXED)
        begin
            next_state.mv = RDM_MV_FIXED;
        end
        else if (code > RDM_CODE_SAT)
        begin
            next_state.mv = RDM_MV_SAT;
        end
        else
        begin
            next_state.mv = RDM_MV_BASE + 11'(RDM_MV_STEP * {5'h00, code});
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state.mv <= RDM_MV_RST;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign millivolts = state.mv;
endmodule

//--- sim/rdm_testbench.sv
// self-checking testbench for the discharge and mode setting 0 register bank
`timescale 1ns/100ps
module testbench
    import rdm_pkg::*;
;
    typedef struct {string name; int sel; logic [15:0] exp;} rdm_note_s;

    logic        clk_sys, rst, nv_pin_select, reg_wr_en, reg_rd_en;
    logic [5:0]  nv_voltage_code, core_buck_voltage_code;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
    logic [3:0]  en, bleed;
    logic [3:0]  pins;
    logic [1:0]  mode_select;
    logic        ship_mode_request, pin_driven_mode_select;
    logic [10:0] core_buck_millivolts;
    rdm_note_s   notes[$];
    rdm_note_s   cur;
    int          fail_count, n_compared;

    rdm_regbank rdm_regbank_inst (
        .clk_sys(clk_sys), .rst(rst), .nv_pin_select(nv_pin_select),
        .nv_voltage_code(nv_voltage_code), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
        .core_buck_enabled(en[3]), .system_buck_enabled(en[2]),
        .always_on_regulator_enabled(en[1]), .system_linear_regulator_enabled(en[0]),
        .core_buck_bleed_on(bleed[3]), .system_buck_bleed_on(bleed[2]),
        .always_on_reg_bleed_on(bleed[1]), .system_linreg_bleed_on(bleed[0]),
        .mode_pin_low(pins[0]), .mode_pin_high(pins[1]),
        .mode_request_bit_low(pins[2]), .mode_request_bit_high(pins[3]),
        .mode_select(mode_select), .ship_mode_request(ship_mode_request),
        .pin_driven_mode_select(pin_driven_mode_select),
        .core_buck_voltage_code(core_buck_voltage_code),
        .core_buck_millivolts(core_buck_millivolts));

    // 50 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] observe(int sel);
        case (sel)
            0: return {8'h00, reg_rdata};
            1: return {12'h000, bleed};
            2: return {14'h0000, mode_select};
            3: return {13'h0000, ship_mode_request, pin_driven_mode_select, 1'b0};
            4: return {10'h000, core_buck_voltage_code};
            default: return {5'h00, core_buck_millivolts};
        endcase
    endfunction

    // expected decode, worked out independently of the design
    function automatic logic [15:0] mv_of(logic [5:0] c);
        if (c == 6'h3f) return 16'd1800;
        if (c > 6'h28) return 16'd1500;
        return 16'd500 + 16'd25 * c;
    endfunction

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic note(string name, int sel, logic [15:0] exp);
        notes.push_back('{name, sel, exp});
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge clk_sys) #1;
        {reg_wr_en, reg_addr, reg_wdata} = {1'b1, a, v};
        @(posedge clk_sys) #1;
        reg_wr_en = 1'b0;
    endtask

    // read result is registered, so the monitor sees it one edge after the strobe
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk_sys) #1;
        {reg_rd_en, reg_addr} = {1'b1, a};
        note("reg_rdata", 0, {8'h00, e});
        @(posedge clk_sys) #1;
        reg_rd_en = 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // monitor: half a nanosecond after each edge, outputs have settled
    always @(posedge clk_sys)
    begin
        #0.5;
        // pop first so name, selector and expectation come from one note
        while (notes.size() > 0)
        begin
            cur = notes.pop_front();
            check(cur.name, observe(cur.sel), cur.exp);
        end
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        {rst, nv_pin_select, reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = 20'h8_0000;
        {en, pins, nv_voltage_code, d} = 22'h00_0000;
        nv_voltage_code = 6'h14;
        void'($urandom(80826));
        repeat (4) @(posedge clk_sys);
        #1 rst = 1'b0;
        note("bleed", 1, 16'h000f);
        note("millivolts", 5, 16'd1000);
        rd(8'h21, 8'h00);
        rd(8'h22, 8'h14);
        // every off-bit pattern against random enables, reserved bits random too
        for (int i = 0; i < 16; i++)
        begin
            d = {4'($urandom), 4'(i)};
            en = 4'($urandom);
            wr(8'h21, d);
            note("bleed", 1, {12'h000, ~en & ~d[3:0]});
            rd(8'h21, d);
        end
        // mode source, ship and voltage, boundary codes first
        for (int i = 0; i < 10; i++)
        begin
            d = 8'($urandom);
            d[6] = i[1]; // both mode sources seen whatever the seed
            if (i < 6) d[5:0] = (i[0] ? 6'h01 : 6'h00) + (i < 2 ? 6'h00 : i < 4 ? 6'h28 : 6'h3e);
            pins = 4'($urandom);
            wr(8'h22, d);
            note("mode_select", 2, d[6] ? pins[1:0] : pins[3:2]);
            note("ship_pin_sel", 3, {13'h0000, d[7:6], 1'b0});
            note("voltage_code", 4, {10'h000, d[5:0]});
            note("millivolts", 5, mv_of(d[5:0]));
            rd(8'h22, d);
        end
        // unmapped write ignored, unmapped read gives zero
        wr(8'h23, 8'hff);
        rd(8'h22, d);
        rd(8'h23, 8'h00);
        // second reset with other nonvolatile defaults
        @(posedge clk_sys) #1;
        {rst, nv_pin_select, nv_voltage_code} = {2'b11, 6'($urandom)};
        repeat (2) @(posedge clk_sys);
        #1 rst = 1'b0;
        rd(8'h22, {2'b01, nv_voltage_code});
        rd(8'h21, 8'h00);
        note("mode_select", 2, pins[1:0]);
        repeat (3) @(posedge clk_sys);
        if (notes.size() != 0) fail_count++;
        tally_and_finish();
    end
endmodule
